// ==== hw/cmpa_ctrl.sv ====
// Comparator A control register, event detector and debouncer.
// Assumes analog comparator output synchronous to CLK_SYS.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module cmpa_ctrl (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Analog side
	input wire logic CMP_RAW,
	input wire logic T1_OVF,
	input wire logic PWR_DOWN,
	input wire logic [3:0] PIN_INPUT_ONLY,
	output logic [3:0] ANALOG_PIN_SEL,
	output logic [3:0] DIG_IN_DISABLE,
	output logic CMP_OUT,
	// Interrupt
	output logic IRQ
);
	import cmpa_pkg::*;

	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] gie_reg, gie_next;
	logic [1:0] stat_reg, stat_next;
	logic [1:0] mask_reg, mask_next;
	logic wr_reg, wr_next;
	logic [7:0] addr_reg, addr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic prev_reg, prev_next;
	logic pend_reg, pend_next;
	logic exp_reg, exp_next;
	logic [1:0] ovf_reg, ovf_next;
	logic [3:0] sel_reg, sel_next;
	logic [3:0] dis_reg, dis_next;
	logic out_reg, out_next;
	logic irq_reg, irq_next;
	logic enabled, cmp_s, rise, fall, ev, db_done, db_ok, rd_stat;
	logic start_db, flag_wr0, acc;
	mode_t mode;

	// Power-down overrides the enable bit.
	assign enabled = ctrl_reg[EN_BIT] && !PWR_DOWN;
	assign cmp_s = enabled && CMP_RAW;
	assign mode = mode_t'(ctrl_reg[2:0]);
	assign rise = cmp_s && !prev_reg;
	assign fall = !cmp_s && prev_reg;
	// Each register is one aligned word, so byte lanes and stray high
	// address bits are refused rather than aliased onto a register.
	assign acc = HSEL && HREADY && HTRANS[1] && HADDR[31:10] == 22'h0 &&
		HADDR[1:0] == 2'h0;
	assign flag_wr0 = wr_reg && addr_reg == ACTRL_OFS && !HWDATA[FLAG_BIT];
	assign rd_stat = acc && !HWRITE && HADDR[9:2] == ISTAT_OFS;
	assign db_done = pend_reg && ovf_reg == DEB_OVF;
	assign db_ok = db_done && cmp_s == exp_reg;

	always_comb begin
		start_db = 1'b0;
		ev = 1'b0;
		case (mode)
			M_LOW: ev = !cmp_s && enabled;
			M_HIGH: ev = cmp_s;
			M_RISE: ev = rise;
			M_FALL: ev = fall;
			M_TOG_DB: start_db = rise || fall;
			M_RISE_DB: start_db = rise;
			M_FALL_DB, M_FALL_DB2: start_db = fall;
			default: ev = 1'b0;
		endcase
		// Gating here, not only at the edge detector, keeps the fall that
		// disabling itself causes from raising the flag.
		ev = enabled && (ev || db_ok);
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		gie_next = gie_reg;
		mask_next = mask_reg;
		stat_next = stat_reg;
		wr_next = acc && HWRITE;
		addr_next = acc ? HADDR[9:2] : addr_reg;
		rdata_next = 32'h0;
		prev_next = cmp_s;
		pend_next = pend_reg;
		exp_next = exp_reg;
		ovf_next = ovf_reg;
		if (wr_reg) begin
			case (addr_reg)
				ACTRL_OFS: ctrl_next = {HWDATA[7:5], ctrl_reg[FLAG_BIT] &&
					HWDATA[FLAG_BIT], HWDATA[3:0]};
				GIE_OFS: gie_next = HWDATA[7:0];
				IMASK_OFS: mask_next = HWDATA[1:0];
				default: ;
			endcase
		end
		if (rd_stat)
			stat_next = 2'h0;
		if (acc && !HWRITE) begin
			case (HADDR[9:2])
				ACTRL_OFS: rdata_next = {24'h0, ctrl_reg};
				GIE_OFS: rdata_next = {24'h0, gie_reg};
				IMASK_OFS: rdata_next = {30'h0, mask_reg};
				ISTAT_OFS: rdata_next = {30'h0, stat_reg};
				default: rdata_next = 32'h0;
			endcase
		end
		// Debounce restarts on each relevant transition, except while disabled or in the cycle the count ends.
		if (!enabled || db_done) begin
			pend_next = 1'b0;
		end else if (start_db) begin
			pend_next = 1'b1;
			exp_next = cmp_s;
			ovf_next = 2'h0;
		end else if (pend_reg && T1_OVF) begin
			ovf_next = ovf_reg + 2'h1;
		end
		// Set wins over a simultaneous clear.
		if (ev) begin
			ctrl_next[FLAG_BIT] = 1'b1;
			stat_next[0] = 1'b1;
		end
		if (ev && !ctrl_reg[FLAG_BIT] && !flag_wr0)
			stat_next[1] = 1'b1;
		sel_next = 4'h0;
		if (ctrl_reg[CON_BIT])
			sel_next[ctrl_next[7:CSEL_LSB]] = 1'b1;
		dis_next = enabled ? PIN_INPUT_ONLY : 4'h0;
		out_next = cmp_s;
		// IRQ follows the registered flag and status, one cycle behind them,
		// so a clear and a request in the same cycle cannot disagree.
		irq_next = (ctrl_reg[FLAG_BIT] && gie_reg[GIE_BIT]) ||
			|(stat_reg & mask_reg);
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg <= ACTRL_RST;
			gie_reg <= 8'h00;
			mask_reg <= 2'h0;
			stat_reg <= 2'h0;
			wr_reg <= 1'b0;
			addr_reg <= 8'h00;
			rdata_reg <= 32'h0;
			prev_reg <= 1'b0;
			pend_reg <= 1'b0;
			exp_reg <= 1'b0;
			ovf_reg <= 2'h0;
			sel_reg <= 4'h0;
			dis_reg <= 4'h0;
			out_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			gie_reg <= gie_next;
			mask_reg <= mask_next;
			stat_reg <= stat_next;
			wr_reg <= wr_next;
			addr_reg <= addr_next;
			rdata_reg <= rdata_next;
			prev_reg <= prev_next;
			pend_reg <= pend_next;
			exp_reg <= exp_next;
			ovf_reg <= ovf_next;
			sel_reg <= sel_next;
			dis_reg <= dis_next;
			out_reg <= out_next;
			irq_reg <= irq_next;
		end
	end

	assign HRDATA = rdata_reg;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign ANALOG_PIN_SEL = sel_reg;
	assign DIG_IN_DISABLE = dis_reg;
	assign CMP_OUT = out_reg;
	assign IRQ = irq_reg;

	property p_off_low;
		@(posedge CLK_SYS) disable iff (!RST_B)
		!enabled |=> !CMP_OUT;
	endproperty
	a_off_low: assert property (p_off_low) else $error("output not low");

	property p_rise;
		@(posedge CLK_SYS) disable iff (!RST_B)
		mode == M_RISE && rise |=> ctrl_reg[FLAG_BIT];
	endproperty
	a_rise: assert property (p_rise) else $error("rise lost");

	property p_pd;
		@(posedge CLK_SYS) disable iff (!RST_B)
		PWR_DOWN |-> !cmp_s;
	endproperty
	a_pd: assert property (p_pd) else $error("on in power-down");

	property p_gie;
		@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl_reg[FLAG_BIT] && gie_reg[GIE_BIT] |=> IRQ;
	endproperty
	a_gie: assert property (p_gie) else $error("irq missing");

	property p_iso;
		@(posedge CLK_SYS) disable iff (!RST_B)
		!ctrl_reg[CON_BIT] |=> ANALOG_PIN_SEL == 4'h0;
	endproperty
	a_iso: assert property (p_iso) else $error("pins not isolated");

	property p_sel;
		@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl_reg[CON_BIT] && !wr_reg |=>
			ANALOG_PIN_SEL == 4'h1 << $past(ctrl_reg[7:6]);
	endproperty
	a_sel: assert property (p_sel) else $error("wrong pin");

	property p_dis;
		@(posedge CLK_SYS) disable iff (!RST_B)
		enabled |=> DIG_IN_DISABLE == $past(PIN_INPUT_ONLY);
	endproperty
	a_dis: assert property (p_dis) else $error("digital path on");

	property p_w1;
		@(posedge CLK_SYS) disable iff (!RST_B)
		!ctrl_reg[FLAG_BIT] && !ev |=> !ctrl_reg[FLAG_BIT];
	endproperty
	a_w1: assert property (p_w1) else $error("flag set by write");

	property p_db;
		@(posedge CLK_SYS) disable iff (!RST_B)
		pend_reg |-> ovf_reg <= DEB_OVF;
	endproperty
	a_db: assert property (p_db) else $error("debounce count");

	property p_low;
		@(posedge CLK_SYS) disable iff (!RST_B)
		mode == M_LOW && enabled && !cmp_s |=> ctrl_reg[FLAG_BIT];
	endproperty
	a_low: assert property (p_low) else $error("low level lost");

	property p_fall;
		@(posedge CLK_SYS) disable iff (!RST_B)
		mode == M_FALL && enabled && fall |=> ctrl_reg[FLAG_BIT];
	endproperty
	a_fall: assert property (p_fall) else $error("fall lost");

	property p_high;
		@(posedge CLK_SYS) disable iff (!RST_B)
		mode == M_HIGH && cmp_s |=> ctrl_reg[FLAG_BIT];
	endproperty
	a_high: assert property (p_high) else $error("high level lost");

	property p_pend;
		@(posedge CLK_SYS) disable iff (!RST_B)
		mode == M_TOG_DB && enabled && !db_done && (rise || fall) |=> pend_reg;
	endproperty
	a_pend: assert property (p_pend) else $error("toggle not timed");

	property p_deb_set;
		@(posedge CLK_SYS) disable iff (!RST_B)
		db_ok && enabled |=> ctrl_reg[FLAG_BIT];
	endproperty
	a_deb_set: assert property (p_deb_set) else $error("debounce lost");

	property p_discard;
		@(posedge CLK_SYS) disable iff (!RST_B)
		db_done && !db_ok && mode == M_RISE_DB && !ctrl_reg[FLAG_BIT] |=>
			!ctrl_reg[FLAG_BIT];
	endproperty
	a_discard: assert property (p_discard) else $error("glitch kept");

	property p_block;
		@(posedge CLK_SYS) disable iff (!RST_B)
		!enabled && !ctrl_reg[FLAG_BIT] |=> !ctrl_reg[FLAG_BIT];
	endproperty
	a_block: assert property (p_block) else $error("event while off");

	property p_rdclr;
		@(posedge CLK_SYS) disable iff (!RST_B)
		rd_stat && !ev |=> stat_reg == 2'h0;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("status kept");

	property p_mask;
		@(posedge CLK_SYS) disable iff (!RST_B)
		(stat_reg & mask_reg) != 2'h0 |=> IRQ;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq missing");

	property p_quiet;
		@(posedge CLK_SYS) disable iff (!RST_B)
		!(ctrl_reg[FLAG_BIT] && gie_reg[GIE_BIT]) &&
			(stat_reg & mask_reg) == 2'h0 |=> !IRQ;
	endproperty
	a_quiet: assert property (p_quiet) else $error("stray irq");

	c_db: cover property (@(posedge CLK_SYS) db_ok);
	c_irq: cover property (@(posedge CLK_SYS) $rose(IRQ));
	c_low: cover property (@(posedge CLK_SYS) mode == M_LOW && ev);
	c_fall: cover property (@(posedge CLK_SYS) mode == M_FALL && ev);
	c_discard: cover property (@(posedge CLK_SYS) db_done && !db_ok);
endmodule : cmpa_ctrl
`default_nettype wire

// ==== pkg/cmpa_pkg.sv ====
// Constants for the comparator A control and status block.
// Assumes a single system clock and an AHB-Lite register port.
package cmpa_pkg;
	// Offsets are word indices; the bus byte address is four times the index.
	localparam logic [7:0] ACTRL_OFS = 8'h97;
	localparam logic [7:0] ACTRL_RST = 8'h00;
	localparam logic [7:0] IMASK_OFS = 8'hA0;
	localparam logic [7:0] ISTAT_OFS = 8'hA4;
	localparam logic [7:0] GIE_OFS = 8'hA8;
	localparam int CSEL_LSB = 6;
	localparam int CON_BIT = 5;
	localparam int FLAG_BIT = 4;
	localparam int EN_BIT = 3;
	localparam int GIE_BIT = 6;
	localparam logic [1:0] DEB_OVF = 2'h2;
	typedef enum logic [2:0] {
		M_LOW, M_RISE, M_TOG_DB, M_RISE_DB, M_FALL, M_FALL_DB, M_HIGH,
		M_FALL_DB2
	} mode_t;
endpackage : cmpa_pkg

// ==== tb/cmpa_far_side.sv ====
// Far side model: comparator output from the routed pin, and Timer 1.
// Assumes the bench sets which pins sit above the minus input.
`timescale 1ns/1ps
`default_nettype none
module cmpa_far_side (
	// Clock
	input wire logic CLK_SYS,
	// Pins and timer
	input wire logic [3:0] ANALOG_PIN_SEL,
	input wire logic [3:0] pin_above,
	input wire logic t1_run,
	output logic CMP_RAW,
	output logic T1_OVF
);
	logic [3:0] cnt = 4'h0;
	// An isolated plus input reads low, so stale levels never leak.
	assign CMP_RAW = |(ANALOG_PIN_SEL & pin_above);
	always @(posedge CLK_SYS) begin
		if (t1_run) cnt <= cnt + 4'h1;
	end
	assign T1_OVF = t1_run && (cnt == 4'hF);
endmodule : cmpa_far_side
`default_nettype wire

// ==== tb/comparator_a_control_status_test.sv ====
// Self-checking bench for the comparator A control block.
// Assumes zero wait states and a far side model of the comparator.
`timescale 1ns/1ps
`default_nettype none
module comparator_a_control_status_test;
	import cmpa_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST_B = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic PWR_DOWN = 1'b0;
	logic t1_run = 1'b0;
	logic [3:0] PIN_INPUT_ONLY = 4'h0;
	logic [3:0] lvl = 4'h0;
	wire logic [31:0] HRDATA;
	wire logic HREADYOUT, HRESP, CMP_RAW, T1_OVF, CMP_OUT, IRQ;
	wire logic [3:0] ANALOG_PIN_SEL, DIG_IN_DISABLE;
	logic rd_dp = 1'b0;
	logic sn = 1'b0;
	logic [32:0] q[$];
	logic [32:0] e, g;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	// Each entry: mode, start level, end level, glitch, expected flag.
	logic [6:0] tab [10] = '{7'h09, 7'h15, 7'h49, 7'h44, 7'h65, 7'h29,
		7'h35, 7'h59, 7'h79, 7'h36};
	always #2.5 CLK_SYS = ~CLK_SYS;
	cmpa_ctrl u_cmpa_ctrl (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMP_RAW(CMP_RAW),
		.T1_OVF(T1_OVF), .PWR_DOWN(PWR_DOWN),
		.PIN_INPUT_ONLY(PIN_INPUT_ONLY), .ANALOG_PIN_SEL(ANALOG_PIN_SEL),
		.DIG_IN_DISABLE(DIG_IN_DISABLE), .CMP_OUT(CMP_OUT), .IRQ(IRQ));
	cmpa_far_side u_cmpa_far_side (.CLK_SYS(CLK_SYS),
		.ANALOG_PIN_SEL(ANALOG_PIN_SEL), .pin_above(lvl),
		.t1_run(t1_run), .CMP_RAW(CMP_RAW), .T1_OVF(T1_OVF));
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {22'h0, a, 2'h0};
		HWRITE <= w;
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= {24'h0, d};
		rd_dp <= !w;
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		rd_dp <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		q.push_back({1'b1, 24'h0, x});
		bus(1'b0, a, 8'h00);
	endtask : rd
	// Outputs are registered behind the register, so let them settle.
	task automatic snap(input logic [9:0] x);
		q.push_back({23'h0, x});
		repeat (3) @(posedge CLK_SYS);
		sn <= 1'b1;
		@(posedge CLK_SYS);
		sn <= 1'b0;
	endtask : snap
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (rd_dp) begin
			samples_checked++;
			if (HRESP !== 1'b0) begin
				$display("[FAIL] hresp exp 0 got %b", HRESP);
				error_cnt++;
			end
		end
		if ((rd_dp || sn) && q.size() > 0) begin
			e = q.pop_front();
			g = e[32] ? {1'b1, HRDATA} : {23'h0, IRQ, CMP_OUT,
				DIG_IN_DISABLE, ANALOG_PIN_SEL};
			samples_checked++;
			if (g !== e) begin
				$display("[FAIL] %s exp %h got %h", e[32] ? "rd" : "pins",
					e, g);
				error_cnt++;
			end
		end
		// The run needs about 950 cycles; the ceiling leaves ample room.
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(32'hA99D));
		repeat (6) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		@(posedge CLK_SYS);
		PIN_INPUT_ONLY <= 4'($urandom);
		rd(ACTRL_OFS, ACTRL_RST);
		rd(8'h40, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(ACTRL_OFS, {k[1:0], 6'h09});
			wr(ACTRL_OFS, {k[1:0], 6'h29});
			snap({2'b00, PIN_INPUT_ONLY, 4'h1 << k});
			wr(ACTRL_OFS, {k[1:0], 6'h09});
		end
		wr(ACTRL_OFS, 8'hE1);
		lvl <= 4'hF;
		snap({2'b00, 4'h0, 4'h8});
		rd(ACTRL_OFS, 8'hE1);
		lvl <= 4'h0;
		wr(ACTRL_OFS, 8'hE9);
		lvl <= 4'hF;
		snap({2'b01, PIN_INPUT_ONLY, 4'h8});
		rd(ACTRL_OFS, 8'hF9);
		wr(GIE_OFS, 8'h40);
		snap({2'b11, PIN_INPUT_ONLY, 4'h8});
		wr(ACTRL_OFS, 8'hE9);
		wr(ACTRL_OFS, 8'hF9);
		rd(ACTRL_OFS, 8'hE9);
		t1_run <= 1'b1;
		foreach (tab[i]) begin
			lvl <= {4{tab[i][3]}};
			repeat (40) @(posedge CLK_SYS);
			wr(ACTRL_OFS, {5'h1D, tab[i][6:4]});
			lvl <= {4{tab[i][2]}};
			if (tab[i][1]) repeat (2) @(posedge CLK_SYS);
			if (tab[i][1]) lvl <= {4{tab[i][3]}};
			repeat (40) @(posedge CLK_SYS);
			rd(ACTRL_OFS, {3'h7, tab[i][0], 1'b1, tab[i][6:4]});
		end
		rd(ISTAT_OFS, 8'h03);
		rd(ISTAT_OFS, 8'h00);
		wr(GIE_OFS, 8'h00);
		wr(IMASK_OFS, 8'h01);
		wr(ACTRL_OFS, 8'hE9);
		lvl <= 4'hF;
		snap({2'b11, PIN_INPUT_ONLY, 4'h8});
		rd(ISTAT_OFS, 8'h03);
		snap({2'b01, PIN_INPUT_ONLY, 4'h8});
		PWR_DOWN <= 1'b1;
		snap({2'b00, 4'h0, 4'h8});
		end_of_test();
	end
endmodule : comparator_a_control_status_test
`default_nettype wire
